// *** hw/sfe_erase_ctrl.sv ***
// erase command decoder and self-timed erase sequencer
module sfe_erase_ctrl
    import sfe_pkg::*;
#(
    parameter int unsigned SECTOR_CYCLES = SECTOR_ERASE_CYCLES,
    parameter int unsigned BLOCK32_CYCLES = BLOCK32_ERASE_CYCLES,
    parameter int unsigned BLOCK64_CYCLES = BLOCK64_ERASE_CYCLES,
    parameter int unsigned CHIP_CYCLES = CHIP_ERASE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // serial link pins
    input wire logic spi_cs_n_i,
    input wire logic spi_clk_i,
    input wire logic [3:0] spi_io_i,
    output logic [3:0] spi_io_o,
    output logic [3:0] spi_io_oe_n_o,
    // mode and protection settings
    input wire logic quad_command_mode_i,
    input wire logic addr_4byte_mode_i,
    input wire logic protect_complement_i,
    input wire logic protect_top_bottom_i,
    input wire logic [3:0] protect_level_i,
    input wire logic latch_set_i,
    // status and array request
    output logic busy_o,
    output logic write_enable_latch_o,
    output logic erase_start_o,
    output sfe_erase_req_type erase_req_o
);

    // pin synchronisers, {cs, clk, io}
    logic [5:0] sync_meta; // first stage, read only by sync_pin
    logic [5:0] sync_pin; // second stage
    logic clk_prev; // last sampled link clock
    logic cs_prev; // last sampled chip select

    // two flops per pin before any use
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sync_meta <= 6'h30;
            sync_pin <= 6'h30;
            clk_prev <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            sync_meta <= {spi_cs_n_i, spi_clk_i, spi_io_i};
            sync_pin <= sync_meta;
            clk_prev <= sync_pin[4];
            cs_prev <= sync_pin[5];
        end
    end

    // edge events of the link
    logic cs_n; // synced select
    logic clk_rise; // sample edge inside a frame
    logic clk_fall; // launch edge inside a frame
    logic cs_rise; // frame end
    assign cs_n = sync_pin[5];
    assign clk_rise = sync_pin[4] & ~clk_prev & ~cs_n;
    assign clk_fall = ~sync_pin[4] & clk_prev & ~cs_n;
    assign cs_rise = cs_n & ~cs_prev;

    // frame capture state
    logic [5:0] bit_cnt; // bits received, saturating
    logic [5:0] next_bit_cnt;
    logic [39:0] shift_in; // opcode and address bits
    logic [39:0] next_shift_in;
    logic [7:0] opcode; // first byte of the frame
    logic [7:0] next_opcode;
    logic [6:0] cnt_sum; // one extra bit to catch overflow

    // shift one lane in spi, four in quad mode
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_opcode = opcode;
        cnt_sum = {1'b0, bit_cnt} + (quad_command_mode_i ? 7'h04 : 7'h01);
        if (cs_n) begin
            // idle select: start over, forget opcode
            next_bit_cnt = 6'h00;
            next_opcode = 8'h00;
        end else if (clk_rise) begin
            next_shift_in = quad_command_mode_i ? {shift_in[35:0], sync_pin[3:0]}
                                                : {shift_in[38:0], sync_pin[0]};
            // saturate so an overlong frame never looks exact
            next_bit_cnt = cnt_sum[6] ? BITS_SATURATED : cnt_sum[5:0];
            if (next_bit_cnt == OPCODE_BITS) begin
                next_opcode = next_shift_in[7:0];
            end
        end
    end

    // frame registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            bit_cnt <= 6'h00;
            shift_in <= 40'h0000000000;
            opcode <= 8'h00;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            opcode <= next_opcode;
        end
    end

    // erase sequencer state
    sfe_state_type state; // idle or erasing
    sfe_state_type next_state;
    logic [31:0] timer; // cycles left in the erase
    logic [31:0] next_timer;
    logic latch; // write enable latch
    logic next_latch;
    logic busy; // erase in progress
    logic next_busy;
    logic start; // one-cycle start strobe
    logic next_start;
    sfe_erase_req_type req; // request held for the array
    sfe_erase_req_type next_req;

    // live status byte, also read during erase
    logic [7:0] status_live;
    always_comb begin
        status_live = 8'h00;
        status_live[STATUS_BUSY_BIT] = busy;
        status_live[STATUS_LATCH_BIT] = latch;
    end

    // status read output
    logic [2:0] out_idx; // next status bit to launch
    logic [2:0] next_out_idx;
    logic [3:0] io_out;
    logic [3:0] next_io_out;
    logic [3:0] io_oe_n;
    logic [3:0] next_io_oe_n;
    logic status_read; // read-status frame past its opcode

    // launch status bits on falling link edges, busy or not
    always_comb begin
        status_read = (opcode == OP_READ_STATUS) && (bit_cnt >= OPCODE_BITS);
        next_out_idx = out_idx;
        next_io_out = io_out;
        next_io_oe_n = io_oe_n;
        if (!status_read) begin
            // released lines while not answering
            next_out_idx = 3'h0;
            next_io_oe_n = 4'hF;
        end else if (clk_fall) begin
            if (quad_command_mode_i) begin
                next_io_out = out_idx[2] ? status_live[3:0] : status_live[7:4];
                next_io_oe_n = 4'h0;
                next_out_idx = out_idx + 3'h4;
            end else begin
                next_io_out = {2'b00, status_live[3'h7 - out_idx], 1'b0};
                next_io_oe_n = 4'hD;
                next_out_idx = out_idx + 3'h1;
            end
        end
    end

    // output pin registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_idx <= 3'h0;
            io_out <= 4'h0;
            io_oe_n <= 4'hF;
        end else begin
            out_idx <= next_out_idx;
            io_out <= next_io_out;
            io_oe_n <= next_io_oe_n;
        end
    end

    // command decode at frame end
    logic is_erase; // opcode names an erase
    logic is_chip; // whole-array erase
    logic [5:0] addr_bits; // address length wanted
    logic [26:0] length; // bytes covered
    logic [31:0] cycles; // erase duration
    logic [31:0] addr; // received address
    logic [26:0] tgt_lo; // aligned target start
    logic [26:0] tgt_hi; // target end, exclusive
    logic frame_ok; // select rose right after last bit
    logic [26:0] prot_size; // bytes in the protect band
    logic [26:0] prot_lo;
    logic [26:0] prot_hi;
    logic guarded; // target touches protected area
    logic accept;

    // opcode table
    always_comb begin
        is_erase = 1'b1;
        is_chip = 1'b0;
        addr_bits = addr_4byte_mode_i ? ADDR4_BITS : ADDR3_BITS;
        length = SECTOR_BYTES;
        cycles = SECTOR_CYCLES;
        case (opcode)
            OP_SECTOR: begin
                length = SECTOR_BYTES;
            end
            OP_SECTOR_A32: begin
                addr_bits = ADDR4_BITS;
            end
            OP_BLOCK32: begin
                length = BLOCK32_BYTES;
                cycles = BLOCK32_CYCLES;
            end
            OP_BLOCK64: begin
                length = BLOCK64_BYTES;
                cycles = BLOCK64_CYCLES;
            end
            OP_BLOCK64_A32: begin
                addr_bits = ADDR4_BITS;
                length = BLOCK64_BYTES;
                cycles = BLOCK64_CYCLES;
            end
            OP_CHIP_A, OP_CHIP_B: begin
                is_chip = 1'b1;
                addr_bits = 6'h00;
                length = ARRAY_BYTES;
                cycles = CHIP_CYCLES;
            end
            default: begin
                is_erase = 1'b0;
            end
        endcase
    end

    // address, exact length check, protection band
    always_comb begin
        addr = (addr_bits == ADDR4_BITS) ? shift_in[31:0] : {8'h00, shift_in[23:0]};
        frame_ok = (bit_cnt == OPCODE_BITS + addr_bits);
        // address bits above the array wrap; whole unit aligned down
        tgt_lo = {1'b0, addr[ARRAY_ADDR_W-1:0]} & ~(length - 27'h0000001);
        tgt_hi = tgt_lo + length;
        // band doubles per level from one unit, capped at the array
        if (protect_level_i == 4'h0) begin
            prot_size = 27'h0000000;
        end else if (protect_level_i >= 4'hB) begin
            prot_size = ARRAY_BYTES;
        end else begin
            prot_size = PROTECT_UNIT_BYTES << (protect_level_i - 4'h1);
        end
        prot_lo = protect_top_bottom_i ? 27'h0000000 : ARRAY_BYTES - prot_size;
        prot_hi = protect_top_bottom_i ? prot_size : ARRAY_BYTES;
        if (is_chip) begin
            // any protected byte blocks the whole-array erase
            guarded = protect_complement_i ? (prot_size != ARRAY_BYTES)
                                           : (prot_size != 27'h0000000);
        end else if (protect_complement_i) begin
            // complement: only the band itself stays writable
            guarded = !((tgt_lo >= prot_lo) && (tgt_hi <= prot_hi));
        end else begin
            guarded = (prot_size != 27'h0000000) && (tgt_lo < prot_hi)
                      && (tgt_hi > prot_lo);
        end
        // latch clear or busy: silently dropped, nothing changes
        accept = cs_rise && is_erase && frame_ok && latch && !guarded
                 && (state == SFE_IDLE);
    end

    // sequencer next values
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_latch = latch;
        next_busy = busy;
        next_start = 1'b0;
        next_req = req;
        case (state)
            SFE_IDLE: begin
                if (accept) begin
                    next_state = SFE_BUSY;
                    next_timer = cycles - 32'h00000001;
                    next_busy = 1'b1;
                    next_start = 1'b1;
                    next_req.base = is_chip ? 32'h00000000 : {5'h00, tgt_lo};
                    next_req.length = {5'h00, length};
                    next_req.all_dies = is_chip;
                end
            end
            SFE_BUSY: begin
                if (timer == 32'h00000000) begin
                    next_state = SFE_IDLE;
                    next_busy = 1'b0;
                    next_latch = 1'b0;
                end else begin
                    next_timer = timer - 32'h00000001;
                end
            end
            default: begin
                next_state = SFE_IDLE;
                next_busy = 1'b0;
            end
        endcase
        // a set arriving with the completion clear wins
        if (latch_set_i) begin
            next_latch = 1'b1;
        end
    end

    // sequencer registers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state <= SFE_IDLE;
            timer <= 32'h00000000;
            latch <= 1'b0;
            busy <= 1'b0;
            start <= 1'b0;
            req <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            latch <= next_latch;
            busy <= next_busy;
            start <= next_start;
            req <= next_req;
        end
    end

    // outputs straight from flops
    assign spi_io_o = io_out;
    assign spi_io_oe_n_o = io_oe_n;
    assign busy_o = busy;
    assign write_enable_latch_o = latch;
    assign erase_start_o = start;
    assign erase_req_o = req;

endmodule // sfe_erase_ctrl

// *** hw/sfe_pkg.sv ***
// constants and types for the serial flash erase command logic
package sfe_pkg;
    // command opcodes
    localparam logic [7:0] OP_SECTOR = 8'h20;
    localparam logic [7:0] OP_SECTOR_A32 = 8'h21;
    localparam logic [7:0] OP_BLOCK32 = 8'h52;
    localparam logic [7:0] OP_BLOCK64 = 8'hD8;
    localparam logic [7:0] OP_BLOCK64_A32 = 8'hDC;
    localparam logic [7:0] OP_CHIP_A = 8'hC7;
    localparam logic [7:0] OP_CHIP_B = 8'h60;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    // array geometry, erased byte value
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int ARRAY_ADDR_W = 26;
    localparam logic [26:0] ARRAY_BYTES = 27'h4000000;
    localparam logic [26:0] SECTOR_BYTES = 27'h0001000;
    localparam logic [26:0] BLOCK32_BYTES = 27'h0008000;
    localparam logic [26:0] BLOCK64_BYTES = 27'h0010000;
    localparam logic [26:0] PROTECT_UNIT_BYTES = 27'h0010000;
    // frame lengths in bits
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] ADDR3_BITS = 6'h18;
    localparam logic [5:0] ADDR4_BITS = 6'h20;
    localparam logic [5:0] BITS_SATURATED = 6'h3F;
    // status byte layout
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_LATCH_BIT = 1;
    // erase times in microseconds, converted at the system clock rate
    localparam longint unsigned CLK_MHZ = 25;
    localparam longint unsigned SECTOR_ERASE_TIME_US = 50000;
    localparam longint unsigned BLOCK32_ERASE_TIME_US = 120000;
    localparam longint unsigned BLOCK64_ERASE_TIME_US = 150000;
    localparam longint unsigned CHIP_ERASE_TIME_US = 100000000;
    localparam int unsigned SECTOR_ERASE_CYCLES = 32'(SECTOR_ERASE_TIME_US * CLK_MHZ);
    localparam int unsigned BLOCK32_ERASE_CYCLES = 32'(BLOCK32_ERASE_TIME_US * CLK_MHZ);
    localparam int unsigned BLOCK64_ERASE_CYCLES = 32'(BLOCK64_ERASE_TIME_US * CLK_MHZ);
    localparam int unsigned CHIP_ERASE_CYCLES = 32'(CHIP_ERASE_TIME_US * CLK_MHZ);
    // request handed to the array
    typedef struct packed {
        logic [31:0] base;
        logic [31:0] length;
        logic all_dies;
    } sfe_erase_req_type;
    // sequencer states
    typedef enum logic [0:0] {
        SFE_IDLE = 1'b0,
        SFE_BUSY = 1'b1
    } sfe_state_type;
endpackage

// *** bench/sfe_erase_ctrl_sva.sv ***
// assertion checker for the erase command logic
module sfe_erase_ctrl_sva
    import sfe_pkg::*;
#(
    parameter int unsigned SECTOR_CYCLES = 1,
    parameter int unsigned BLOCK32_CYCLES = 1,
    parameter int unsigned BLOCK64_CYCLES = 1,
    parameter int unsigned CHIP_CYCLES = 1
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // watched inputs
    input wire logic spi_cs_n_i,
    input wire logic latch_set_i,
    // watched outputs
    input wire logic [3:0] spi_io_oe_n_o,
    input wire logic busy_o,
    input wire logic write_enable_latch_o,
    input wire logic erase_start_o,
    input wire sfe_erase_req_type erase_req_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // busy cycles since the last start
    int unsigned run_len;
    int unsigned next_run_len;
    // restart on start, count while busy
    always_comb begin
        next_run_len = run_len;
        if (rst_i) begin
            next_run_len = 0;
        end else if (erase_start_o) begin
            next_run_len = 1;
        end else if (busy_o) begin
            next_run_len = run_len + 1;
        end
    end
    // register only
    always_ff @(posedge sys_clk_i) begin
        run_len <= next_run_len;
    end
    // start pulse opens a busy run
    sequence s_launch;
        erase_start_o ##0 busy_o;
    endsequence
    property p_launch;
        s_launch |=> busy_o && !erase_start_o;
    endproperty
    a_launch: assert property (p_launch) else $error("start without busy run");
    property p_gate;
        erase_start_o |-> !$past(busy_o) && $past(write_enable_latch_o);
    endproperty
    a_gate: assert property (p_gate) else $error("start without latch");
    property p_cs_high;
        erase_start_o |-> spi_cs_n_i && $past(spi_cs_n_i, 2);
    endproperty
    a_cs_high: assert property (p_cs_high) else $error("start inside frame");
    // run length checked when busy drops; the request still names that erase
    sequence s_done;
        $fell(busy_o);
    endsequence
    property p_sec_time;
        s_done ##0 (erase_req_o.length == 32'(SECTOR_BYTES)) |-> run_len == SECTOR_CYCLES;
    endproperty
    a_sec_time: assert property (p_sec_time) else $error("sector time");
    property p_b32_time;
        s_done ##0 (erase_req_o.length == 32'(BLOCK32_BYTES)) |-> run_len == BLOCK32_CYCLES;
    endproperty
    a_b32_time: assert property (p_b32_time) else $error("block32 time");
    property p_b64_time;
        s_done ##0 (erase_req_o.length == 32'(BLOCK64_BYTES)) |-> run_len == BLOCK64_CYCLES;
    endproperty
    a_b64_time: assert property (p_b64_time) else $error("block64 time");
    property p_chip_time;
        s_done ##0 erase_req_o.all_dies |-> run_len == CHIP_CYCLES;
    endproperty
    a_chip_time: assert property (p_chip_time) else $error("chip time");
    property p_latch_drop;
        $fell(busy_o) && !$past(latch_set_i) |-> !write_enable_latch_o;
    endproperty
    a_latch_drop: assert property (p_latch_drop) else $error("latch kept");
    property p_chip_span;
        erase_start_o && erase_req_o.all_dies |->
            erase_req_o.base == 32'h0 && erase_req_o.length == 32'(ARRAY_BYTES);
    endproperty
    a_chip_span: assert property (p_chip_span) else $error("chip span");
    property p_align;
        erase_start_o |-> (erase_req_o.base & (erase_req_o.length - 32'h1)) == 32'h0;
    endproperty
    a_align: assert property (p_align) else $error("base unaligned");
    // no drive once the frame is long over
    property p_float;
        spi_cs_n_i [*8] |-> spi_io_oe_n_o == 4'hF;
    endproperty
    a_float: assert property (p_float) else $error("driving while idle");
endmodule // sfe_erase_ctrl_sva

bind sfe_erase_ctrl sfe_erase_ctrl_sva #(
    .SECTOR_CYCLES(SECTOR_CYCLES),
    .BLOCK32_CYCLES(BLOCK32_CYCLES),
    .BLOCK64_CYCLES(BLOCK64_CYCLES),
    .CHIP_CYCLES(CHIP_CYCLES)
) sfe_erase_ctrl_sva_inst (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .spi_cs_n_i(spi_cs_n_i),
    .latch_set_i(latch_set_i),
    .spi_io_oe_n_o(spi_io_oe_n_o),
    .busy_o(busy_o),
    .write_enable_latch_o(write_enable_latch_o),
    .erase_start_o(erase_start_o),
    .erase_req_o(erase_req_o)
);

// *** bench/sfe_host_model.sv ***
// host controller model that frames link transfers
module sfe_host_model (
    // system clock
    input wire logic sys_clk_i,
    // link pins toward the device
    output logic cs_n_o,
    output logic clk_o,
    output logic [3:0] io_o,
    // resolved data lines
    input wire logic [3:0] io_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // link clock parked low between frames
    initial begin
        cs_n_o = 1'b1;
        clk_o = 1'b0;
        io_o = 4'h5;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // v msb first; q sends a nibble per edge; rd keeps the last 8 bits read back
    task automatic xfer(input logic [39:0] v, input int n, input logic q,
                        output logic [7:0] rd);
        rd = 8'h00;
        tick(1);
        cs_n_o <= 1'b0;
        tick(4);
        for (int i = 0; i < (q ? n / 4 : n); i++) begin
            io_o <= q ? v[39:36] : {v[38:36], v[39]};
            v = q ? v << 4 : v << 1;
            tick(4);
            clk_o <= 1'b1;
            rd = q ? {rd[3:0], io_i} : {rd[6:0], io_i[1]};
            tick(4);
            clk_o <= 1'b0;
        end
        tick(4);
        // frame ends right after the last bit
        cs_n_o <= 1'b1;
        // released lines must not keep the last value
        io_o <= ~io_o;
        tick(8);
    endtask
endmodule // sfe_host_model

// *** bench/sfe_erase_ctrl_test.sv ***
// self-checking bench for the erase command logic
module sfe_erase_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sfe_pkg::*;
    // long erase counts shortened, status read fits in a run
    localparam int unsigned SEC_N = 300;
    localparam int unsigned B32_N = 320;
    localparam int unsigned B64_N = 340;
    localparam int unsigned CHP_N = 360;
    logic clk, rst, cs_n, sck, quad, a4, inv_band, low_band, latch_set, busy, latch, start;
    logic [3:0] lvl, hio, dout, oe_n, line;
    sfe_erase_req_type req;
    sfe_erase_req_type exp_q[$];
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] seed = 16'hDCDE;
    logic [7:0] ops [7] = '{OP_SECTOR, OP_SECTOR_A32, OP_BLOCK32, OP_BLOCK64,
        OP_BLOCK64_A32, OP_CHIP_A, OP_CHIP_B};
    int abits [7] = '{24, 32, 24, 24, 32, 0, 0};
    // {invert, bottom, ok, 0, level, address}
    logic [39:0] prot [5] = '{40'h0103FFF000, 40'h2103FE0000, 40'h4100000000,
        40'hA103FF0000, 40'h8100000000};
    // wire level from both parties
    assign line = (~oe_n & dout) | (oe_n & hio);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    sfe_erase_ctrl #(.SECTOR_CYCLES(SEC_N), .BLOCK32_CYCLES(B32_N),
        .BLOCK64_CYCLES(B64_N), .CHIP_CYCLES(CHP_N)) sfe_erase_ctrl_inst (
        .sys_clk_i(clk), .rst_i(rst), .spi_cs_n_i(cs_n), .spi_clk_i(sck),
        .spi_io_i(line), .spi_io_o(dout), .spi_io_oe_n_o(oe_n),
        .quad_command_mode_i(quad), .addr_4byte_mode_i(a4),
        .protect_complement_i(inv_band), .protect_top_bottom_i(low_band),
        .protect_level_i(lvl), .latch_set_i(latch_set), .busy_o(busy),
        .write_enable_latch_o(latch), .erase_start_o(start), .erase_req_o(req));
    sfe_host_model sfe_host_model_inst (.sys_clk_i(clk), .cs_n_o(cs_n),
        .clk_o(sck), .io_o(hio), .io_i(line));
    task automatic wrap_up;
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic note(input logic bad, input string msg);
        total_checks++;
        if (bad) begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic chk_req(input sfe_erase_req_type got, input sfe_erase_req_type want);
        note(got !== want, "erase request");
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] want, input string msg);
        note(got !== want, msg);
    endtask
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 2; i++) begin
            seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
            rnd = {rnd[15:0], seed};
        end
    endfunction
    function automatic logic [31:0] len_of(input logic [7:0] op);
        case (op)
            OP_SECTOR, OP_SECTOR_A32: len_of = 32'(SECTOR_BYTES);
            OP_BLOCK32: len_of = 32'(BLOCK32_BYTES);
            OP_BLOCK64, OP_BLOCK64_A32: len_of = 32'(BLOCK64_BYTES);
            default: len_of = 32'(ARRAY_BYTES);
        endcase
    endfunction
    // host sets the latch; every erase but the first runs with it set
    task automatic arm;
        latch_set <= 1'b1;
        @(posedge clk);
        latch_set <= 1'b0;
        @(posedge clk);
    endtask
    // status read in the current lane mode: one bit or one nibble per edge
    task automatic stat(input logic [7:0] want, input logic q);
        logic [7:0] rd;
        sfe_host_model_inst.xfer({OP_READ_STATUS, 32'h0}, 16, q, rd);
        chk_byte(rd, want, "status byte");
    endtask
    // one erase frame; ok says whether it must start
    task automatic erase(input logic [7:0] op, input logic [31:0] a, input int ab,
                         input logic q, input logic ok);
        sfe_erase_req_type e;
        logic [7:0] rd;
        logic w0;
        a = (ab == 24) ? (a & 32'h00FFFFFF) : a;
        w0 = latch;
        e.all_dies = (op == OP_CHIP_A || op == OP_CHIP_B);
        e.length = len_of(op);
        e.base = e.all_dies ? 32'h0 : a & 32'h03FFFFFF & ~(e.length - 32'h1);
        if (ok) exp_q.push_back(e);
        sfe_host_model_inst.xfer({op, a << (32 - ab)}, 8 + ab, q, rd);
        if (ok) begin
            stat(8'h03, q);
            repeat (2000) if (busy === 1'b1) @(posedge clk);
            chk_byte({6'h0, latch, busy}, 8'h00, "flags after erase");
        end else begin
            repeat (20) @(posedge clk);
            chk_byte({6'h0, latch, busy}, {6'h0, w0, 1'b0}, "refused flags");
        end
    endtask
    // each start is judged against the oldest note
    always @(negedge clk) begin
        if (start === 1'b1) begin
            if (exp_q.size() == 0) begin
                note(1'b1, "erase not expected");
            end else begin
                chk_req(req, exp_q.pop_front());
            end
        end
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 60000) begin
            note(1'b1, "timeout");
            wrap_up();
        end
    end
    initial begin
        rst = 1'b1;
        quad = 1'b0;
        a4 = 1'b0;
        inv_band = 1'b0;
        low_band = 1'b0;
        lvl = 4'h0;
        latch_set = 1'b0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        erase(OP_SECTOR, rnd(), 24, 1'b0, 1'b0);
        // spi 3-byte, quad 3-byte, spi 4-byte
        for (int m = 0; m < 3; m++) begin
            for (int k = 0; k < 7; k++) begin
                quad <= (m == 1);
                a4 <= (m == 2);
                arm();
                erase(ops[k], rnd(), (m == 2 && abits[k] == 24) ? 32 : abits[k],
                    m == 1, 1'b1);
            end
        end
        a4 <= 1'b0;
        quad <= 1'b0;
        arm();
        // latch set, idle: tells the busy and latch bit positions apart
        stat(8'h02, 1'b0);
        erase(OP_SECTOR, rnd(), 23, 1'b0, 1'b0);
        erase(OP_SECTOR, rnd(), 25, 1'b0, 1'b0);
        erase(OP_CHIP_A, 32'h0, 8, 1'b0, 1'b0);
        for (int k = 0; k < 5; k++) begin
            inv_band <= prot[k][39];
            low_band <= prot[k][38];
            lvl <= prot[k][35:32];
            arm();
            erase(OP_SECTOR_A32, prot[k][31:0], 32, 1'b0, prot[k][37]);
        end
        inv_band <= 1'b0;
        arm();
        erase(OP_CHIP_B, 32'h0, 0, 1'b0, 1'b0);
        note(exp_q.size() != 0, "missing erase");
        wrap_up();
    end
endmodule // sfe_erase_ctrl_test
